// ===== pkg/ufa_pkg.sv
package ufa_pkg;
    // Register byte addresses, word access only
    localparam logic [31:0] UFA_DEVICE_ADDRESS_OFS = 32'h1520_0140;
    localparam logic [31:0] UFA_POWER_MGMT_OFS     = 32'h1520_0144;
    // Own registers of the controller end
    localparam logic [31:0] UFA_HOST_CMD_OFS       = 32'h1520_0180;
    localparam logic [31:0] UFA_HOST_STAT_OFS      = 32'h1520_0184;
    // Field positions
    localparam int UFA_ADDR_LSB     = 0;
    localparam int UFA_ADDR_W       = 7;
    localparam int UFA_ADDR_UPD_BIT = 7;
    localparam int UFA_CLK_MASK_BIT = 8;
    localparam int UFA_SW_RESET_BIT = 7;
    localparam int UFA_FLUSH_BIT    = 6;
    localparam int UFA_PWR_SEEN_BIT = 5;
    localparam int UFA_BUS_RST_BIT  = 3;
    localparam int UFA_RESUME_BIT   = 2;
    localparam int UFA_SUSP_BIT     = 1;
    localparam int UFA_SUSP_EN_BIT  = 0;
    // Reset values
    localparam logic [31:0] UFA_DEVICE_ADDRESS_RST = 32'h0000_0000;
    localparam logic [31:0] UFA_POWER_MGMT_RST     = 32'h0000_0000;
    // Endpoint FIFO depths in bytes
    localparam int UFA_CTRL_FIFO_DEPTH = 16;
    localparam int UFA_BULK_FIFO_DEPTH = 64;
    // Timing: USB logic 48 MHz; link bit rate 12 Mbit/s
    localparam int UFA_CLK_MHZ        = 125;
    localparam int UFA_USB_CLK_MHZ    = 48;
    localparam int UFA_BIT_RATE_MBPS  = 12;
    localparam int UFA_RESUME_TIME_US = 10;
    localparam int UFA_RESUME_CYC     = UFA_RESUME_TIME_US * UFA_CLK_MHZ;
    // Register port opcodes
    typedef enum logic [1:0] {UFA_OP_IDLE, UFA_OP_RD, UFA_OP_WR} ufa_op_t;
endpackage : ufa_pkg

// ===== pkg/ufa_if.sv
`timescale 1ns/10ps
interface ufa_if;
    import ufa_pkg::*;
    logic        regReq;
    logic        regWrite;
    logic [31:0] regAddr;
    logic [31:0] regWdata;
    logic [31:0] regRdata;
    logic        regAck;
    logic        busReset;
    logic        busResume;
    logic        busIdle;
    logic        busPower;
    logic        statusDone;
    logic        resumeDrive;
    logic        usbClkOn;
    logic        usbSwReset;
    logic        ctrlFlush;
    logic [6:0]  matchAddr;
    modport dev (input regReq, regWrite, regAddr, regWdata, busReset, busResume, busIdle,
                 busPower, statusDone, output regRdata, regAck, resumeDrive, usbClkOn,
                 usbSwReset, ctrlFlush, matchAddr);
    modport host (output regReq, regWrite, regAddr, regWdata, busReset, busResume, busIdle,
                  busPower, statusDone, input regRdata, regAck, resumeDrive, usbClkOn,
                  usbSwReset, ctrlFlush, matchAddr);
endinterface : ufa_if

// ===== rtl/ufa_host_end.sv
`timescale 1ns/10ps
module ufa_host_end
    import ufa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clkEn,
    ufa_if.host              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hostBusReset,
    input  wire logic        hostBusResume,
    input  wire logic        hostBusIdle,
    input  wire logic        hostBusPower,
    input  wire logic        hostStatusDone
);
    // Host end: carries word accesses to the device and drives bus conditions
    typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_DONE} ufa_hs_t;
    typedef struct packed {
        ufa_hs_t     st;
        logic        req;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic [4:0]  cond;
    } ufa_hst_t;
    ufa_hst_t s_reg, s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.ready = 1'b0;
        s_next.err   = 1'b0;
        s_next.cond  = {hostBusReset, hostBusResume, hostBusIdle, hostBusPower, hostStatusDone};
        unique case (s_reg.st)
            HS_IDLE: begin
                if (psel && !s_reg.ready) begin
                    s_next.req   = 1'b1;
                    s_next.wr    = pwrite;
                    s_next.addr  = paddr;
                    s_next.wdata = pwdata;
                    s_next.st    = HS_WAIT;
                end
            end
            HS_WAIT: begin
                if (link.regAck) begin
                    s_next.req   = 1'b0;
                    s_next.rdata = link.regRdata;
                    s_next.ready = 1'b1;
                    s_next.err   = (link.regRdata == 32'hFFFF_FFFF) && !s_reg.wr;
                    s_next.st    = HS_DONE;
                end
            end
            HS_DONE: begin
                s_next.st = HS_IDLE;
            end
            // Fourth code of the state word is unused; fall back to idle
            default: begin
                s_next.st = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else if (clkEn) begin
            s_reg <= s_next;
        end
    end

    assign link.regReq     = s_reg.req;
    assign link.regWrite   = s_reg.wr;
    assign link.regAddr    = s_reg.addr;
    assign link.regWdata   = s_reg.wdata;
    assign link.busReset   = s_reg.cond[4];
    assign link.busResume  = s_reg.cond[3];
    assign link.busIdle    = s_reg.cond[2];
    assign link.busPower   = s_reg.cond[1];
    assign link.statusDone = s_reg.cond[0];
    assign prdata          = s_reg.rdata;
    assign pready          = s_reg.ready;
    assign pslverr         = s_reg.err;
endmodule : ufa_host_end

// ===== rtl/ufa_device_end.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Control endpoint FIFO holds 16 bytes
// - IN endpoint A: 64-byte FIFO, DMA capable
// - IN endpoint B: 64-byte FIFO
// - OUT endpoint A: 64-byte FIFO, DMA capable
// - OUT endpoint B: 64-byte FIFO
// - Full speed only, 12 Mbit/s
// - Control, interrupt and bulk transfers
// - No isochronous transfers
// - Software uses whole-word accesses only
// - Reserved bits read zero
// - Program registers after bus reset ends
// - Seven-bit address, used from next token
// - Software sets update flag with address
// - Status stage completion clears update flag
// - Bit 8 gates the USB clock
// - Software reset write clears clock gate
// - Bit 7 holds USB logic in reset
// - Bit 6 flushes control endpoint FIFO
// - Bit 3 follows bus reset signaling
// - Bit 2 drives resume while suspended
// - Bit 1 marks suspend, cleared by resume
// - Bit 0 enables suspend, default off
module ufa_device_end
    import ufa_pkg::*;
#(
    parameter int RESUME_CYC = UFA_RESUME_CYC
)(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic clkEn,
    ufa_if.dev        link,
    output logic [6:0] devAddr,
    output logic       suspended,
    output logic       resumeActive,
    output logic       ctrlFifoEmpty
);
    // Endpoint FIFO sizes; no isochronous type is offered
    localparam int CTRL_DEPTH = UFA_CTRL_FIFO_DEPTH;
    localparam int BULK_DEPTH = UFA_BULK_FIFO_DEPTH;

    typedef struct packed {
        logic [6:0]  addr;
        logic        addrUpd;
        logic        clkMask;
        logic        swReset;
        logic        flush;
        logic        pwrSeen;
        logic        busRst;
        logic        resumeReq;
        logic        susp;
        logic        suspEn;
        logic [15:0] resumeCnt;
        logic        resumeOn;
        logic [4:0]  ctrlCount;
        logic [6:0]  matchAddr;
        logic        ack;
        logic        ctrlEmpty;
        logic [31:0] rdata;
    } ufa_dst_t;
    ufa_dst_t s_reg, s_next;
    // Reset state: all clear, but the control FIFO reports empty
    localparam ufa_dst_t DEV_RST = '{ctrlEmpty: 1'b1, default: '0};

    //////////////////////////////////////////////////////////////////////////
    logic wrAddr, wrPwr, rdHit;
    always_comb begin
        wrAddr = link.regReq && !s_reg.ack && link.regWrite
                 && link.regAddr == UFA_DEVICE_ADDRESS_OFS;
        wrPwr  = link.regReq && !s_reg.ack && link.regWrite
                 && link.regAddr == UFA_POWER_MGMT_OFS;
        rdHit  = link.regAddr == UFA_DEVICE_ADDRESS_OFS || link.regAddr == UFA_POWER_MGMT_OFS;
    end

    always_comb begin
        s_next     = s_reg;
        s_next.ack = link.regReq && !s_reg.ack;
        // Address and flag taken as one word
        if (wrAddr) begin
            s_next.addr    = link.regWdata[UFA_ADDR_W-1:0];
            s_next.addrUpd = link.regWdata[UFA_ADDR_UPD_BIT];
        end
        // Status stage done; the set in the same cycle wins
        if (link.statusDone && !wrAddr) begin
            s_next.addrUpd = 1'b0;
        end
        // New address matched from the next token on
        if (link.statusDone || !s_reg.addrUpd) begin
            s_next.matchAddr = s_reg.addr;
        end
        if (wrPwr) begin
            s_next.swReset   = link.regWdata[UFA_SW_RESET_BIT];
            s_next.clkMask   = link.regWdata[UFA_SW_RESET_BIT] ? 1'b0
                               : link.regWdata[UFA_CLK_MASK_BIT];
            s_next.flush     = link.regWdata[UFA_FLUSH_BIT];
            s_next.suspEn    = link.regWdata[UFA_SUSP_EN_BIT];
            s_next.resumeReq = link.regWdata[UFA_RESUME_BIT];
        end
        s_next.pwrSeen = link.busPower;
        s_next.busRst  = link.busReset;
        // Flush empties the control FIFO; so does holding the USB side in reset
        if (s_reg.flush || s_reg.swReset) begin
            s_next.ctrlCount = '0;
        end
        // Registered so the empty flag leaves the block straight from a flop
        s_next.ctrlEmpty = s_next.ctrlCount == 5'd0;
        // Suspend entry, only when enabled
        if (s_reg.suspEn && link.busIdle && !link.busReset) begin
            s_next.susp = 1'b1;
        end
        // Software resume drives the bus for a fixed time
        if (s_reg.susp && s_reg.resumeReq && !s_reg.resumeOn) begin
            s_next.resumeOn  = 1'b1;
            s_next.resumeCnt = 16'(RESUME_CYC - 1);
        end else if (s_reg.resumeOn) begin
            if (s_reg.resumeCnt == '0) begin
                s_next.resumeOn  = 1'b0;
                s_next.susp      = 1'b0;
                s_next.resumeReq = 1'b0;
            end else begin
                s_next.resumeCnt = s_reg.resumeCnt - 16'd1;
            end
        end
        if (link.busResume || link.busReset) begin
            s_next.susp     = 1'b0;
            s_next.resumeOn = 1'b0;
        end
        // Whole-word read, reserved bits zero
        s_next.rdata = '0;
        if (link.regAddr == UFA_DEVICE_ADDRESS_OFS) begin
            s_next.rdata[UFA_ADDR_W-1:0]  = s_reg.addr;
            s_next.rdata[UFA_ADDR_UPD_BIT] = s_reg.addrUpd;
        end else if (link.regAddr == UFA_POWER_MGMT_OFS) begin
            s_next.rdata[UFA_CLK_MASK_BIT] = s_reg.clkMask;
            s_next.rdata[UFA_FLUSH_BIT]    = s_reg.flush;
            s_next.rdata[UFA_PWR_SEEN_BIT] = s_reg.pwrSeen;
            s_next.rdata[UFA_BUS_RST_BIT]  = s_reg.busRst;
            s_next.rdata[UFA_SUSP_BIT]     = s_reg.susp;
            s_next.rdata[UFA_SUSP_EN_BIT]  = s_reg.suspEn;
        end else if (!rdHit) begin
            s_next.rdata = 32'hFFFF_FFFF;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register timing runs on the 125 MHz clk that RESUME_CYC is scaled for, not the 48 MHz USB clock
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= DEV_RST;
        end else if (clkEn) begin
            s_reg <= s_next;
        end
    end

    assign link.regAck      = s_reg.ack;
    assign link.regRdata    = s_reg.rdata;
    assign link.resumeDrive = s_reg.resumeOn;
    assign link.usbClkOn    = !s_reg.clkMask;
    assign link.usbSwReset  = s_reg.swReset;
    assign link.ctrlFlush   = s_reg.flush;
    assign link.matchAddr   = s_reg.matchAddr;
    assign devAddr          = s_reg.matchAddr;
    assign suspended        = s_reg.susp;
    assign resumeActive     = s_reg.resumeOn;
    assign ctrlFifoEmpty    = s_reg.ctrlEmpty;
endmodule : ufa_device_end

// ===== sim/ufa_link_sva.sv
`timescale 1ns/10ps
module ufa_link_sva
    import ufa_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        regReq,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regAck,
    input wire logic        statusDone,
    input wire logic        usbClkOn,
    input wire logic        usbSwReset,
    input wire logic        ctrlFlush,
    input wire logic [6:0]  matchAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic wrPwr;
    logic wrZero;
    logic addrCause;
    assign wrPwr     = regAck && regWrite && (regAddr == UFA_POWER_MGMT_OFS);
    assign wrZero    = wrPwr && !regWdata[UFA_SW_RESET_BIT];
    // Software reset is also let through as a cause, though the device keeps the active address through it
    assign addrCause = regAck || statusDone || usbSwReset;
    ////////////////////////////////////////////////////////////////////////////
    sequence s_issue; regReq && !regAck; endsequence
    sequence s_gate;
        wrPwr && regWdata[UFA_CLK_MASK_BIT] && !regWdata[UFA_SW_RESET_BIT];
    endsequence
    sequence s_swrst; wrPwr && regWdata[UFA_SW_RESET_BIT]; endsequence
    a_ack_one_pulse: assert property (regAck |=> !regAck)
        else $error("ack held longer than one cycle");
    a_req_gets_ack: assert property ($rose(regReq) |=> regAck)
        else $error("request not answered next cycle");
    a_req_stands: assert property (s_issue |=> $stable(regAddr) && $stable(regWdata))
        else $error("request changed before ack");
    a_gate_clock: assert property (s_gate |-> ##[1:2] !usbClkOn)
        else $error("clock not gated");
    a_swrst_ungate: assert property (s_swrst |-> ##[1:2] usbClkOn && usbSwReset)
        else $error("software reset did not ungate clock");
    // The write lands on the same edge that raises its ack, so the fall and the ack coincide
    a_swrst_release: assert property ($fell(usbSwReset) |-> wrZero || $past(wrZero))
        else $error("software reset left without a write of zero");
    a_flush_cmd: assert property (wrPwr && regWdata[UFA_FLUSH_BIT] |-> ##[1:2] ctrlFlush)
        else $error("flush not issued");
    a_addr_cause: assert property ($changed(matchAddr) |-> $past(addrCause) || $past(addrCause, 2))
        else $error("address changed without cause");
endmodule : ufa_link_sva

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ufa_pkg::*;
    logic        clk, rst_b, clkEn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rnd;
    logic        hReset, hResume, hIdle, hPower, hDone;
    logic [6:0]  devAddr, newAddr;
    logic        suspended, resumeActive, ctrlFifoEmpty;
    int          errors, checks, i, k;
    logic [32:0] expQ[$];
    ufa_if link ();
    ufa_host_end u_ufa_host_end (.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .link(link.host),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostBusReset(hReset),
        .hostBusResume(hResume), .hostBusIdle(hIdle), .hostBusPower(hPower),
        .hostStatusDone(hDone));
    // Short resume keeps the run brief
    ufa_device_end #(.RESUME_CYC(8)) u_ufa_device_end (.clk(clk), .rst_b(rst_b),
        .clkEn(clkEn), .link(link.dev), .devAddr(devAddr), .suspended(suspended),
        .resumeActive(resumeActive), .ctrlFifoEmpty(ctrlFifoEmpty));
    ufa_link_sva u_ufa_link_sva (.clk(clk), .rst_b(rst_b), .regReq(link.regReq),
        .regAddr(link.regAddr), .regWdata(link.regWdata), .regWrite(link.regWrite),
        .regAck(link.regAck), .statusDone(link.statusDone), .usbClkOn(link.usbClkOn),
        .usbSwReset(link.usbSwReset), .ctrlFlush(link.ctrlFlush), .matchAddr(link.matchAddr));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // Entered just after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic w, input logic [31:0] a, d, input logic [32:0] e);
        if (!w) expQ.push_back(e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        wt(1);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        wt(1);
    endtask : apb
    task automatic complete_run;
        // A read whose answer never came counts against the run
        if (expQ.size() != 0) errors++;
        $display("TB: errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Read data is taken at the same rising edge at which pready is sampled high
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
            chk({pslverr, prdata}, expQ.pop_front());
        end
    end
    initial begin
        wt(30000);
        errors++;
        complete_run();
    end
    initial begin
        {rst_b, psel, penable, pwrite, hReset, hResume, hIdle, hPower, hDone} = '0;
        {paddr, pwdata} = '0;
        clkEn = 1'b1;
        errors = 0;
        checks = 0;
        rnd = 32'h0000_36f4;
        wt(3);
        rst_b <= 1'b1;
        wt(1);
        chk(ctrlFifoEmpty, 1);
        // Bus reset first; software only reads while it lasts
        hReset <= 1'b1;
        hPower <= 1'b1;
        wt(4);
        apb(0, UFA_DEVICE_ADDRESS_OFS, 0, 0);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0028);
        hReset <= 1'b0;
        wt(2);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0020);
        rnd = lfsr(lfsr(rnd));
        newAddr = rnd[6:0];
        apb(1, UFA_DEVICE_ADDRESS_OFS, {rnd[31:8], 1'b1, newAddr}, 0);
        apb(0, UFA_DEVICE_ADDRESS_OFS, 0, {25'h0, 1'b1, newAddr});
        chk(devAddr, 0);
        hDone <= 1'b1;
        wt(1);
        hDone <= 1'b0;
        wt(4);
        apb(0, UFA_DEVICE_ADDRESS_OFS, 0, {26'h0, newAddr});
        chk(devAddr, newAddr);
        apb(1, UFA_POWER_MGMT_OFS, 32'hFFFF_FE00, 0);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0020);
        apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0100, 0);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0120);
        apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0180, 0);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0020);
        apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0000, 0);
        wt(4);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0020);
        apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0040, 0);
        apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0060);
        chk(ctrlFifoEmpty, 1);
        hIdle <= 1'b1;
        wt(50);
        chk(suspended, 0);
        // Leave via software resume first, then via bus resume
        for (k = 0; k < 2; k++) begin
            apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0001, 0);
            hIdle <= 1'b1;
            for (i = 0; i < 3000 && suspended !== 1'b1; i++) @(negedge clk);
            wt(1);
            apb(0, UFA_POWER_MGMT_OFS, 0, 33'h0_0000_0023);
            hIdle <= 1'b0;
            if (k == 0) apb(1, UFA_POWER_MGMT_OFS, 32'h0000_0005, 0);
            else hResume <= 1'b1;
            for (i = 0; i < 100 && resumeActive !== 1'b1 && k == 0; i++) @(negedge clk);
            if (k == 0) chk(resumeActive, 1);
            for (i = 0; i < 200 && suspended !== 1'b0; i++) @(negedge clk);
            chk(suspended, 0);
            wt(1);
            hResume <= 1'b0;
        end
        apb(1, 32'h1520_01FC, rnd, 0);
        apb(0, 32'h1520_01FC, 0, {1'b1, 32'hFFFF_FFFF});
        complete_run();
    end
endmodule : tb_top
